// >>> hw/multipurpose_port_mux.sv
// apb slave with pin mode, function and analog routing for an 8-pin port
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_map.svh"

// Operation
// - four pairs switch to analog by bits 3:0
// - four internal analog lines shared by pins
// - analog mode overrides function and digital setup
// - enabled function overrides digital setup
// - default after reset is plain digital
// - cpu clock pin 2, 32 kHz pin 3
// - pwm0 on pin 0, pwm1 on pin 1
// - serial sig0 pin 4, sig1 pin 5
// - uart tx pin 6, rx pin 7
// - odd pin line from out bits x,x-1
// - even pin line from dir bits x+1,x
// - direction bit: 0 input, 1 output
// - output register drives pin, reads back
// - input status shows pin levels
// - open-drain bit selects open-drain drive
// - pullup bit enables pin pullup
// - open-drain driven low disables pullup
// - config reset clears all port registers except input status
// - open-drain never drives high
// - input buffer on except analog mode and system reset
module multipurpose_port_mux
    import port_mux_pkg::*;
#(
    parameter int NUM_PINS = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        config_reset_select,
    input  wire logic        config_reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pin_pullup,
    output logic      [7:0]  pin_in_buf_en,
    output logic      [7:0]  analog_connect,
    output logic      [15:0] analog_line_sel,
    input  wire logic        pwm0_out,
    input  wire logic        pwm1_out,
    input  wire logic        cpu_clk_out,
    input  wire logic        clk32k_out,
    input  wire logic        sync_serial_sig0,
    input  wire logic        sync_serial_sig1,
    output logic             sync_serial_in0,
    output logic             sync_serial_in1,
    input  wire logic        uart_tx,
    output logic             uart_rx
);

    // the mux and the pair fields are fixed to eight pins
    if (NUM_PINS != 8) begin
        $error("multipurpose_port_mux serves exactly 8 pins");
    end

    port_byte_t pin_out_bits_reg;
    port_byte_t pin_dir_bits_reg;
    port_byte_t open_drain_bits_reg;
    port_byte_t pullup_bits_reg;
    logic [3:0] analog_pair_bits_reg;
    logic [6:0] func_ctrl_reg;
    port_byte_t pin_in_bits_reg;
    pin_mode_t  mode_next [8];

    // port-config reset: either system reset alone, or also the separate config reset
    logic cfg_rst_n;
    assign cfg_rst_n = presetn & (config_reset_select | config_reset_n);

    logic wr_access;
    logic rd_setup;
    assign wr_access = psel & penable & pwrite;
    assign rd_setup  = psel & ~penable & ~pwrite;

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == `OUT_VALUE_OFFSET) || (a == `IN_STATUS_OFFSET) ||
                     (a == `DIRECTION_OFFSET) || (a == `OPEN_DRAIN_OFFSET) ||
                     (a == `PULLUP_OFFSET) || (a == `ANALOG_OFFSET) ||
                     (a == `FUNC_CTRL_OFFSET);
    endfunction

    // write strobe for one register offset
    function automatic logic write_hit(input logic        wr,
                                       input logic [11:0] a, input logic [11:0] off);
        write_hit = wr && (a == off);
    endfunction

    // digital pad level: push-pull follows the value, open-drain only sinks
    function automatic logic digital_level(input logic dir, input logic od, input logic val);
        digital_level = dir & ~od & val;
    endfunction

    // driving when output and either push-pull or an open-drain sinking zero
    function automatic logic digital_oe(input logic dir, input logic od, input logic val);
        digital_oe = dir & (~od | ~val);
    endfunction

    // pullup only on an input or a released open-drain pad
    function automatic logic digital_pullup(input logic dir, input logic od,
                                            input logic val, input logic pu);
        digital_pullup = pu & (~dir | (od & val));
    endfunction

    // analog line of one pin: odd pins read the value bits, even pins the direction bits
    function automatic logic [1:0] line_select(input int idx, input port_byte_t outv,
                                               input port_byte_t dirv);
        if (idx % 2 == 1) begin
            line_select = {outv[idx], outv[idx-1]};
        end else begin
            line_select = {dirv[idx+1], dirv[idx]};
        end
    endfunction

    // output value; in analog mode it also picks the line of odd pins
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            pin_out_bits_reg <= `PORT_RESET_VALUE;
        end else if (write_hit(wr_access, paddr, `OUT_VALUE_OFFSET)) begin
            pin_out_bits_reg <= pwdata[7:0];
        end
    end

    // direction; in analog mode it also picks the line of even pins
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            pin_dir_bits_reg <= `PORT_RESET_VALUE;
        end else if (write_hit(wr_access, paddr, `DIRECTION_OFFSET)) begin
            pin_dir_bits_reg <= pwdata[7:0];
        end
    end

    // open-drain selection, only read in digital mode
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            open_drain_bits_reg <= `PORT_RESET_VALUE;
        end else if (write_hit(wr_access, paddr, `OPEN_DRAIN_OFFSET)) begin
            open_drain_bits_reg <= pwdata[7:0];
        end
    end

    // pullup bits; in analog mode they close the line switch instead
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            pullup_bits_reg <= `PORT_RESET_VALUE;
        end else if (write_hit(wr_access, paddr, `PULLUP_OFFSET)) begin
            pullup_bits_reg <= pwdata[7:0];
        end
    end

    // analog pair selection, upper bits read zero
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            analog_pair_bits_reg <= `ANALOG_RESET_VALUE;
        end else if (write_hit(wr_access, paddr, `ANALOG_OFFSET)) begin
            analog_pair_bits_reg <= pwdata[`ANALOG_FIELD_MSB:0];
        end
    end

    // function enables; all off so the port starts as plain digital
    always_ff @(posedge pclk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            func_ctrl_reg <= `FUNC_CTRL_RESET;
        end else if (write_hit(wr_access, paddr, `FUNC_CTRL_OFFSET)) begin
            func_ctrl_reg <= pwdata[`FUNC_CTRL_MSB:0];
        end
    end

    // pin sample for the input status register; analog pins read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_in_bits_reg <= 8'h00;
        end else begin
            pin_in_bits_reg <= pin_in & pin_in_buf_en;
        end
    end

    // apb answer: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_known(paddr);
            prdata  <= 32'h0000_0000;
            if (rd_setup) begin
                case (paddr)
                    `OUT_VALUE_OFFSET:  prdata[7:0] <= pin_out_bits_reg;
                    `IN_STATUS_OFFSET:  prdata[7:0] <= pin_in_bits_reg;
                    `DIRECTION_OFFSET:  prdata[7:0] <= pin_dir_bits_reg;
                    `OPEN_DRAIN_OFFSET: prdata[7:0] <= open_drain_bits_reg;
                    `PULLUP_OFFSET:     prdata[7:0] <= pullup_bits_reg;
                    `ANALOG_OFFSET:     prdata[3:0] <= analog_pair_bits_reg;
                    `FUNC_CTRL_OFFSET:  prdata[6:0] <= func_ctrl_reg;
                    default:            prdata      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // function enables and values per pin
    logic [7:0] func_en;
    logic [7:0] func_val;
    logic [7:0] func_oe;
    always_comb begin
        func_en  = {func_ctrl_reg[`FUNC_URX_BIT], func_ctrl_reg[`FUNC_UTX_BIT],
                    {2{func_ctrl_reg[`FUNC_SSER_BIT]}}, func_ctrl_reg[`FUNC_CK32K_BIT],
                    func_ctrl_reg[`FUNC_CKCPU_BIT], func_ctrl_reg[`FUNC_PWM1_BIT],
                    func_ctrl_reg[`FUNC_PWM0_BIT]};
        func_val = {1'b0, uart_tx, sync_serial_sig1, sync_serial_sig0,
                    clk32k_out, cpu_clk_out, pwm1_out, pwm0_out};
        // clocks and pwm follow the direction bit; software sets it
        func_oe  = {1'b0, 1'b1, ~sync_serial_sig1, ~sync_serial_sig0,
                    pin_dir_bits_reg[3:0]};
    end

    // per-pin priority: analog, then function, then digital
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (analog_pair_bits_reg[i/2]) begin
                mode_next[i] = MODE_ANALOG;
            end else if (func_en[i]) begin
                mode_next[i] = MODE_FUNCTION;
            end else begin
                mode_next[i] = MODE_DIGITAL;
            end
        end
    end

    // pad output level; open-drain and serial pins never drive high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                case (mode_next[i])
                    MODE_ANALOG: begin
                        pin_out[i] <= 1'b0;
                    end
                    MODE_FUNCTION: begin
                        // serial pins only sink, their level travels in the enable
                        pin_out[i] <= (i == 4 || i == 5) ? 1'b0 : func_val[i];
                    end
                    default: begin
                        pin_out[i] <= digital_level(pin_dir_bits_reg[i],
                                                    open_drain_bits_reg[i],
                                                    pin_out_bits_reg[i]);
                    end
                endcase
            end
        end
    end

    // output enable; every pad setting moves on this same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                case (mode_next[i])
                    MODE_ANALOG: begin
                        pin_oe[i] <= 1'b0;
                    end
                    MODE_FUNCTION: begin
                        pin_oe[i] <= func_oe[i];
                    end
                    default: begin
                        pin_oe[i] <= digital_oe(pin_dir_bits_reg[i],
                                                open_drain_bits_reg[i],
                                                pin_out_bits_reg[i]);
                    end
                endcase
            end
        end
    end

    // pullup; never on a driven pad, which would only waste current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pullup <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                case (mode_next[i])
                    MODE_ANALOG: begin
                        pin_pullup[i] <= 1'b0;
                    end
                    MODE_FUNCTION: begin
                        pin_pullup[i] <= pullup_bits_reg[i] & ~func_oe[i];
                    end
                    default: begin
                        pin_pullup[i] <= digital_pullup(pin_dir_bits_reg[i],
                                                        open_drain_bits_reg[i],
                                                        pin_out_bits_reg[i],
                                                        pullup_bits_reg[i]);
                    end
                endcase
            end
        end
    end

    // input buffer; off in analog mode so a mid-level pad draws no current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_in_buf_en <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                case (mode_next[i])
                    MODE_ANALOG: begin
                        pin_in_buf_en[i] <= 1'b0;
                    end
                    default: begin
                        pin_in_buf_en[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // analog switch; in analog mode the pullup bit closes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_connect <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                case (mode_next[i])
                    MODE_ANALOG: begin
                        analog_connect[i] <= pullup_bits_reg[i];
                    end
                    default: begin
                        analog_connect[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // analog line per pin; held at zero outside analog mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_line_sel <= 16'h0000;
        end else begin
            for (int i = 0; i < 8; i++) begin
                case (mode_next[i])
                    MODE_ANALOG: begin
                        analog_line_sel[2*i +: 2] <= line_select(i, pin_out_bits_reg,
                                                                 pin_dir_bits_reg);
                    end
                    default: begin
                        analog_line_sel[2*i +: 2] <= 2'b00;
                    end
                endcase
            end
        end
    end

    // function inputs; serial inputs read the raw pin, rx only while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_serial_in0 <= 1'b1;
            sync_serial_in1 <= 1'b1;
            uart_rx         <= 1'b1;
        end else begin
            sync_serial_in0 <= pin_in[4];
            sync_serial_in1 <= pin_in[5];
            uart_rx         <= (mode_next[7] == MODE_FUNCTION) ? pin_in[7] : 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> hw/port_mux_map.svh
// register offsets, reset values and field positions of the multipurpose port
`ifndef PORT_MUX_MAP_SVH
`define PORT_MUX_MAP_SVH

`define OUT_VALUE_OFFSET   12'h000
`define IN_STATUS_OFFSET   12'h004
`define DIRECTION_OFFSET   12'h008
`define OPEN_DRAIN_OFFSET  12'h00C
`define PULLUP_OFFSET      12'h010
`define ANALOG_OFFSET      12'h014
`define FUNC_CTRL_OFFSET   12'h018

`define PORT_RESET_VALUE   8'h00
`define ANALOG_FIELD_MSB   3
`define ANALOG_RESET_VALUE 4'h0
`define FUNC_CTRL_RESET    7'h00
`define FUNC_PWM0_BIT      0
`define FUNC_PWM1_BIT      1
`define FUNC_CKCPU_BIT     2
`define FUNC_CK32K_BIT     3
`define FUNC_SSER_BIT      4
`define FUNC_UTX_BIT       5
`define FUNC_URX_BIT       6
`define FUNC_CTRL_MSB      6

`endif

// >>> hw/port_mux_pkg.sv
// types shared by the multipurpose port mux
package port_mux_pkg;
    typedef enum logic [2:0] {
        MODE_DIGITAL  = 3'b001,
        MODE_FUNCTION = 3'b010,
        MODE_ANALOG   = 3'b100
    } pin_mode_t;
    typedef logic [7:0] port_byte_t;
endpackage

// >>> test/port_pad_model.sv
// pad model: resolves each pin from the mux drive, an outside driver and the pullup
`timescale 1ns/1ps
`default_nettype none
module port_pad_model (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] float_pat = 8'h55;
    // a floating pad must never read as a steady level
    always @(posedge pclk) float_pat <= ~float_pat;
    // mux drive wins, then the outside driver, then the pullup
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pin_pullup | float_pat));
endmodule
`default_nettype wire

// >>> test/multipurpose_port_mux_properties.sv
// assertion checker for the port mux pins and register bus
`timescale 1ns/1ps
`default_nettype none
module multipurpose_port_mux_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pin_pullup,
    input wire logic [7:0]  pin_in_buf_en,
    input wire logic [7:0]  analog_connect
);
    // single domain, so one clock and one reset for all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_analog_quiet; (analog_connect & (pin_oe | pin_pullup)) == 8'h00; endproperty
    a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin driven");
    property p_analog_nobuf; (analog_connect & pin_in_buf_en) == 8'h00; endproperty
    a_analog_nobuf: assert property (p_analog_nobuf) else $error("analog pin buffered");
    property p_pullup_idle; (pin_pullup & pin_oe) == 8'h00; endproperty
    a_pullup_idle: assert property (p_pullup_idle) else $error("pullup on driven pin");
    property p_reset_quiet; $rose(presetn) |-> ##1 (pin_oe == 8'h00 && pin_pullup == 8'h00
        && analog_connect == 8'h00 && pin_in_buf_en == 8'hFF); endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("not digital input");
    property p_ready_access; psel && !penable |=> pready; endproperty
    a_ready_access: assert property (p_ready_access) else $error("no ready");
    property p_ready_once; pready |-> psel && penable ##1 !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("stray ready");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_read_upper; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper bits set");
endmodule
bind multipurpose_port_mux multipurpose_port_mux_properties multipurpose_port_mux_properties_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .pin_oe, .pin_pullup, .pin_in_buf_en, .analog_connect);
`default_nettype wire

// >>> test/multipurpose_port_mux_tb_top.sv
// self-checking bench for the multipurpose port mux
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_map.svh"
module multipurpose_port_mux_tb_top;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        config_reset_select = 1'h1, config_reset_n = 1'h1, pwm0_out = 1'h0;
    logic        pwm1_out = 1'h0, cpu_clk_out = 1'h0, clk32k_out = 1'h0, uart_tx = 1'h1;
    logic        sync_serial_sig0 = 1'h1, sync_serial_sig1 = 1'h1, err;
    logic        pready, pslverr, sync_serial_in0, sync_serial_in1, uart_rx;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_in_buf_en, analog_connect;
    logic [7:0]  ext_en = 8'hFF, ext_val = 8'h96;
    logic [15:0] analog_line_sel;
    int          bad_count = 0, tests_run = 0;
    // out, dir, open drain, pullup, then expected oe and pullup
    logic [47:0] rows [4] = '{48'hFFFF00FFFF00, 48'h0FFFFFFFF00F,
                              48'hA500003C003C, 48'h5AF0CC00B000};
    logic [11:0] offs [5] = '{`OUT_VALUE_OFFSET, `DIRECTION_OFFSET, `OPEN_DRAIN_OFFSET,
                              `PULLUP_OFFSET, `ANALOG_OFFSET};
    always #5 pclk = ~pclk;
    multipurpose_port_mux multipurpose_port_mux_i (.pclk, .presetn, .config_reset_select,
        .config_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_in_buf_en, .analog_connect,
        .analog_line_sel, .pwm0_out, .pwm1_out, .cpu_clk_out, .clk32k_out, .sync_serial_sig0,
        .sync_serial_sig1, .sync_serial_in0, .sync_serial_in1, .uart_tx, .uart_rx);
    port_pad_model port_pad_model_i (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val,
        .pin_in);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bus master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h000000, d});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask
    // pins follow one edge after the write, input status one more
    task automatic settle;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 20000 cycles
    initial begin
        #200000;
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        foreach (offs[k]) rdc(offs[k], 32'h0);
        foreach (rows[i]) begin
            wr(`OUT_VALUE_OFFSET, rows[i][47:40]);
            wr(`DIRECTION_OFFSET, rows[i][39:32]);
            wr(`OPEN_DRAIN_OFFSET, rows[i][31:24]);
            wr(`PULLUP_OFFSET, rows[i][23:16]);
            settle;
            chk(pin_oe, rows[i][15:8]);
            chk(pin_pullup, rows[i][7:0]);
            chk(pin_out & pin_oe, rows[i][47:40] & rows[i][15:8]);
            rdc(`IN_STATUS_OFFSET, rows[i][47:40] & rows[i][15:8] | ~rows[i][15:8] & 8'h96);
        end
        $display("digital table done");
        // config reset alone, with the system reset left high
        config_reset_select <= 1'h0;
        config_reset_n <= 1'h0;
        @(posedge pclk);
        config_reset_n <= 1'h1;
        foreach (offs[k]) rdc(offs[k], 32'h0);
        chk({pin_oe, pin_in_buf_en}, 16'h00FF);
        $display("config reset done");
        wr(`DIRECTION_OFFSET, 8'hFF);
        wr(`FUNC_CTRL_OFFSET, 8'h7F);
        pwm0_out <= 1'h1;
        cpu_clk_out <= 1'h1;
        sync_serial_sig0 <= 1'h0;
        settle;
        chk(pin_oe, 8'h5F);
        chk(pin_out & pin_oe, 8'h45);
        chk({uart_rx, sync_serial_in1, sync_serial_in0}, 3'h4);
        {pwm0_out, pwm1_out, cpu_clk_out, clk32k_out, uart_tx} <= 5'h0A;
        ext_val <= 8'h22;
        settle;
        chk(pin_out & pin_oe, 8'h0A);
        chk({uart_rx, sync_serial_in1, sync_serial_in0}, 3'h2);
        $display("functions done");
        wr(`PULLUP_OFFSET, 8'hFF);
        wr(`OUT_VALUE_OFFSET, 8'hE4);
        wr(`DIRECTION_OFFSET, 8'h1B);
        wr(`ANALOG_OFFSET, 8'hFF);
        settle;
        rdc(`ANALOG_OFFSET, 32'h0F);
        chk({analog_connect, analog_line_sel}, 24'hFFC963);
        chk({pin_oe, pin_pullup, pin_in_buf_en}, 24'h0);
        wr(`ANALOG_OFFSET, 8'h05);
        wr(`PULLUP_OFFSET, 8'hEF);
        settle;
        chk({analog_connect, pin_in_buf_en}, 16'h23CC);
        chk({pin_oe, pin_pullup}, 16'h4884);
        $display("analog done");
        apb(1'h1, 12'h01C, 32'hFF);
        chk(err, 1'h1);
        rdc(12'h01C, 32'h0);
        wr(`ANALOG_OFFSET, 8'h00);
        @(negedge pclk);
        chk(analog_connect, 8'h23);
        settle;
        chk(analog_connect, 8'h00);
        $display("refusal and timing done");
        complete_run;
    end
endmodule
`default_nettype wire
